// *** verilog/bom_pkg.sv ***
// shared constants and carrier types for the brownout monitor control block
package bom_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [3:0] IDX_MODE_CONTROL    = 4'h0;
  localparam logic [3:0] IDX_LEVEL_CONTROL   = 4'h1;
  localparam logic [3:0] IDX_WARN_LEVEL_CTRL = 4'h8;
  localparam logic [3:0] IDX_WARN_IRQ_CTRL   = 4'h9;
  localparam logic [3:0] IDX_WARN_IRQ_FLAGS  = 4'ha;
  localparam logic [3:0] IDX_WARN_STATUS     = 4'hb;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int POS_SLEEP_MODE   = 0;  // mode_control[1:0]
  localparam int POS_ACTIVE_MODE  = 2;  // mode_control[3:2]
  localparam int POS_SAMPLE_RATE  = 4;  // mode_control[4]
  localparam int POS_TRIP_LEVEL   = 0;  // level_control[2:0]
  localparam int POS_WARN_OFFSET  = 0;  // warning_level_control[1:0]
  localparam int POS_IRQ_ENABLE   = 0;  // warning_interrupt_control[0]
  localparam int POS_EDGE_SEL     = 1;  // warning_interrupt_control[2:1]
  localparam int POS_IRQ_FLAG     = 0;  // warning_interrupt_flags[0]
  localparam int POS_BELOW_STATUS = 0;  // warning_status[0]

  // ----------------------------------------------------------------------
  // reset values of software-owned fields
  // ----------------------------------------------------------------------
  localparam logic [1:0] RST_WARN_OFFSET = 2'h0;
  localparam logic [1:0] RST_EDGE_SEL    = 2'h0;
  localparam logic       RST_IRQ_ENABLE  = 1'b0;
  localparam logic       RST_IRQ_FLAG    = 1'b0;
  localparam logic       RST_BELOW       = 1'b0;

  // ----------------------------------------------------------------------
  // detector modes, edge selects, rates
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF        = 2'b00,
    MODE_CONTINUOUS = 2'b01,
    MODE_SAMPLED    = 2'b10,
    MODE_CONT_HOLD  = 2'b11
  } bom_mode_e;

  typedef enum logic [1:0] {
    EDGE_FALL_BELOW = 2'b00,
    EDGE_RISE_ABOVE = 2'b01,
    EDGE_ANY        = 2'b10,
    EDGE_RESERVED   = 2'b11
  } bom_edge_e;

  localparam logic RATE_1KHZ  = 1'b0;
  localparam logic RATE_125HZ = 1'b1;

  // ----------------------------------------------------------------------
  // timing: sample periods in microseconds, cycles at 20 MHz
  // ----------------------------------------------------------------------
  localparam int CLK_HZ         = 20_000_000;
  localparam int SAMPLE_FAST_US = 1000;   // 1 kHz
  localparam int SAMPLE_SLOW_US = 8000;   // 125 Hz
  localparam int SAMPLE_FAST_CYC = SAMPLE_FAST_US * (CLK_HZ / 1_000_000);
  localparam int SAMPLE_SLOW_CYC = SAMPLE_SLOW_US * (CLK_HZ / 1_000_000);
  localparam int SAMPLE_CNT_W   = 18;

  // ----------------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       sample_rate;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
    logic [2:0] trip_level;
  } bom_fuse_s;

  typedef struct packed {
    logic warn_below;     // warning comparator: supply below warning level
    logic trip_below;     // trip comparator: supply below trip level
    logic ready;          // detector settled and running
  } bom_analog_s;

  typedef struct packed {
    logic       comp_enable;
    logic [2:0] trip_level;
    logic [1:0] warn_offset;
  } bom_analog_ctl_s;

endpackage : bom_pkg

// *** verilog/bom_sample_timer.sv ***
// sample pulse generator for sampled detector operation
`timescale 1ns/1ps

module bom_sample_timer #(
  parameter int FAST_CYC = bom_pkg::SAMPLE_FAST_CYC,
  parameter int SLOW_CYC = bom_pkg::SAMPLE_SLOW_CYC,
  parameter int CNT_W    = bom_pkg::SAMPLE_CNT_W
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // control
  input  wire logic run,
  input  wire logic rate_sel,
  // result
  output logic      tick
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] last_w;
  logic             tick_r;

  // terminal count follows the selected rate
  assign last_w = (rate_sel == bom_pkg::RATE_125HZ) ?
                  CNT_W'(SLOW_CYC - 1) : CNT_W'(FAST_CYC - 1);

  // ----------------------------------------
  // period counter; held at zero while not sampling
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (cnt_r >= last_w) begin
      cnt_r  <= '0;   // >= also recovers after a rate change
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + CNT_W'(1);
      tick_r <= 1'b0;
    end
  end

  assign tick = tick_r;

endmodule // bom_sample_timer

// *** verilog/bom_ctrl.sv ***
// brownout detector and supply warning monitor control with avalon slave
`timescale 1ns/1ps

// Functional notes
// - sample rate bit: 0 is 1 kHz, 1 is 125 Hz
// - sample rate loaded from fuse, read only
// - active mode codes off, cont, sampled, hold
// - active mode applies in active and idle
// - active mode loaded from fuse, read only
// - sleep mode codes off, cont, sampled; 3 reserved
// - sleep mode loaded from fuse, writable afterwards while config_change_guard is high
// - trip level read only, loaded from fuse
// - warning offset 5, 15, 25 percent; resets zero
// - edge select below, above, or either crossing
// - write 1 enables warning interrupt; resets zero
// - flag set on crossing matching edge select
// - flag only updated while detector enabled
// - status reads 1 while below warning level
// - status meaningful only while detector enabled
// - standby uses sleep mode, wake restores active
// - interrupt held while enable and flag set
module bom_ctrl #(
  parameter int FAST_CYC = bom_pkg::SAMPLE_FAST_CYC,
  parameter int SLOW_CYC = bom_pkg::SAMPLE_SLOW_CYC
) (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  // avalon-mm slave
  input  wire logic [bom_pkg::ADDR_W-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [bom_pkg::DATA_W-1:0]    avs_writedata,
  output logic      [bom_pkg::DATA_W-1:0]    avs_readdata,
  output logic                               avs_waitrequest,
  // boot fuse and system state
  input  wire bom_pkg::bom_fuse_s            fuse_in,
  input  wire logic                          config_change_guard,
  input  wire logic                          deep_sleep,
  // analog comparators
  input  wire bom_pkg::bom_analog_s          analog_in,
  output bom_pkg::bom_analog_ctl_s           analog_ctl,
  // system outputs
  output logic                               brownout_reset,
  output logic                               cpu_hold,
  output logic                               warning_irq
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                       fuse_loaded;
    logic                       sample_rate_sel;
    logic [1:0]                 active_mode;
    logic [1:0]                 sleep_mode;
    logic [2:0]                 trip_level_code;
    logic [1:0]                 warning_offset_sel;
    logic [1:0]                 warning_edge_sel;
    logic                       warning_irq_enable;
    logic                       warning_irq_flag;
    logic                       warning_below_status;
    logic                       warn_seen;
    logic                       comp_enable;
    logic                       bor;
    logic                       hold;
    logic                       irq;
    logic                       waitreq;
    logic [bom_pkg::DATA_W-1:0] rdata;
  } bom_state_s;

  bom_state_s state_r;
  bom_state_s state_nxt;
  logic       sample_tick;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // mode that is live in the present power state
  function automatic logic [1:0] live_mode(input logic       in_deep,
                                           input logic [1:0] act,
                                           input logic [1:0] slp);
    // reserved sleep code is treated as off
    if (in_deep) begin
      live_mode = (slp == 2'b11) ? bom_pkg::MODE_OFF : slp;
    end else begin
      live_mode = act;
    end
  endfunction

  // address decode used by both read and write paths
  function automatic logic hit(input logic [bom_pkg::ADDR_W-1:0] a,
                               input logic [3:0]                 idx);
    hit = (a[bom_pkg::ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  // ----------------------------------------------------------------------
  // sample period generator
  // ----------------------------------------------------------------------
  logic [1:0] mode_now;
  logic       sampling;

  assign mode_now = live_mode(deep_sleep, state_r.active_mode,
                              state_r.sleep_mode);
  assign sampling = state_r.fuse_loaded &&
                    (mode_now == bom_pkg::MODE_SAMPLED);

  bom_sample_timer #(
    .FAST_CYC (FAST_CYC),
    .SLOW_CYC (SLOW_CYC),
    .CNT_W    (bom_pkg::SAMPLE_CNT_W)
  ) u_timer (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .run      (sampling),
    .rate_sel (state_r.sample_rate_sel),
    .tick     (sample_tick)
  );

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic       enabled;
    logic       evaluate;
    logic       req;
    logic       accept_wr;
    logic       crossed_down;
    logic       crossed_up;
    logic       match;
    logic       clr_flag;
    logic [7:0] rd8;
    enabled      = 1'b0;
    evaluate     = 1'b0;
    req          = 1'b0;
    accept_wr    = 1'b0;
    crossed_down = 1'b0;
    crossed_up   = 1'b0;
    match        = 1'b0;
    clr_flag     = 1'b0;
    rd8          = 8'h00;
    state_nxt    = state_r;

    // fuse values are caught on the first cycle after reset release
    if (!state_r.fuse_loaded) begin
      state_nxt.fuse_loaded     = 1'b1;
      state_nxt.sample_rate_sel = fuse_in.sample_rate;
      state_nxt.active_mode     = fuse_in.active_mode;
      state_nxt.sleep_mode      = fuse_in.sleep_mode;
      state_nxt.trip_level_code = fuse_in.trip_level;
    end

    // detector live mode and comparator gating
    enabled = state_r.fuse_loaded && (mode_now != bom_pkg::MODE_OFF);
    case (mode_now)
      bom_pkg::MODE_OFF: begin
        state_nxt.comp_enable = 1'b0;
      end
      bom_pkg::MODE_SAMPLED: begin
        state_nxt.comp_enable = sample_tick;
      end
      bom_pkg::MODE_CONTINUOUS,
      bom_pkg::MODE_CONT_HOLD: begin
        state_nxt.comp_enable = state_r.fuse_loaded;
      end
      default: begin
        state_nxt.comp_enable = 1'b0;
      end
    endcase
    // comparators are read only while the enable pulse is out
    evaluate = enabled && state_r.comp_enable;

    // crossing detection against the last evaluated level
    crossed_down = analog_in.warn_below && !state_r.warn_seen;
    crossed_up   = !analog_in.warn_below && state_r.warn_seen;
    case (state_r.warning_edge_sel)
      bom_pkg::EDGE_FALL_BELOW: match = crossed_down;
      bom_pkg::EDGE_RISE_ABOVE: match = crossed_up;
      bom_pkg::EDGE_ANY:        match = crossed_down || crossed_up;
      default:                  match = 1'b0; // reserved code never fires
    endcase
    if (evaluate) begin
      state_nxt.warn_seen            = analog_in.warn_below;
      state_nxt.warning_below_status = analog_in.warn_below;
    end

    // brownout reset only from an evaluated trip comparator
    state_nxt.bor = evaluate && analog_in.trip_below;

    // execution held at wake until the detector reports running
    state_nxt.hold = state_r.fuse_loaded && !deep_sleep &&
                     (state_r.active_mode == bom_pkg::MODE_CONT_HOLD) &&
                     !analog_in.ready;

    // avalon: one wait cycle, then answer for exactly one cycle
    req       = avs_read || avs_write;
    accept_wr = avs_write && !state_r.waitreq;
    state_nxt.waitreq = !(req && state_r.waitreq);
    if (req && state_r.waitreq) begin
      if (hit(avs_address, bom_pkg::IDX_MODE_CONTROL)) begin
        rd8[bom_pkg::POS_SAMPLE_RATE]      = state_r.sample_rate_sel;
        rd8[bom_pkg::POS_ACTIVE_MODE +: 2] = state_r.active_mode;
        rd8[bom_pkg::POS_SLEEP_MODE +: 2]  = state_r.sleep_mode;
      end else if (hit(avs_address, bom_pkg::IDX_LEVEL_CONTROL)) begin
        rd8[bom_pkg::POS_TRIP_LEVEL +: 3]  = state_r.trip_level_code;
      end else if (hit(avs_address, bom_pkg::IDX_WARN_LEVEL_CTRL)) begin
        rd8[bom_pkg::POS_WARN_OFFSET +: 2] = state_r.warning_offset_sel;
      end else if (hit(avs_address, bom_pkg::IDX_WARN_IRQ_CTRL)) begin
        rd8[bom_pkg::POS_IRQ_ENABLE]       = state_r.warning_irq_enable;
        rd8[bom_pkg::POS_EDGE_SEL +: 2]    = state_r.warning_edge_sel;
      end else if (hit(avs_address, bom_pkg::IDX_WARN_IRQ_FLAGS)) begin
        rd8[bom_pkg::POS_IRQ_FLAG]         = state_r.warning_irq_flag;
      end else if (hit(avs_address, bom_pkg::IDX_WARN_STATUS)) begin
        rd8[bom_pkg::POS_BELOW_STATUS]     = state_r.warning_below_status;
      end
      // unmapped addresses read zero
      state_nxt.rdata = {24'h00_0000, rd8};
    end

    // register writes take effect on the accepting edge
    if (accept_wr) begin
      // active mode, rate and trip level ignore writes
      if (hit(avs_address, bom_pkg::IDX_MODE_CONTROL) &&
          config_change_guard) begin
        state_nxt.sleep_mode =
          avs_writedata[bom_pkg::POS_SLEEP_MODE +: 2];
      end
      if (hit(avs_address, bom_pkg::IDX_WARN_LEVEL_CTRL)) begin
        state_nxt.warning_offset_sel =
          avs_writedata[bom_pkg::POS_WARN_OFFSET +: 2];
      end
      if (hit(avs_address, bom_pkg::IDX_WARN_IRQ_CTRL)) begin
        state_nxt.warning_irq_enable =
          avs_writedata[bom_pkg::POS_IRQ_ENABLE];
        state_nxt.warning_edge_sel =
          avs_writedata[bom_pkg::POS_EDGE_SEL +: 2];
      end
      if (hit(avs_address, bom_pkg::IDX_WARN_IRQ_FLAGS)) begin
        clr_flag = avs_writedata[bom_pkg::POS_IRQ_FLAG];
      end
    end

    // flag: set beats clear so an event is never lost
    if (evaluate && match) begin
      state_nxt.warning_irq_flag = 1'b1;
    end else if (clr_flag) begin
      state_nxt.warning_irq_flag = 1'b0;
    end

    // level request, drops only when flag or enable is cleared
    state_nxt.irq = state_nxt.warning_irq_enable &&
                    state_nxt.warning_irq_flag;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r                      <= '0;
      state_r.warning_offset_sel   <= bom_pkg::RST_WARN_OFFSET;
      state_r.warning_edge_sel     <= bom_pkg::RST_EDGE_SEL;
      state_r.warning_irq_enable   <= bom_pkg::RST_IRQ_ENABLE;
      state_r.warning_irq_flag     <= bom_pkg::RST_IRQ_FLAG;
      state_r.warning_below_status <= bom_pkg::RST_BELOW;
      state_r.waitreq              <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign avs_readdata           = state_r.rdata;
  assign avs_waitrequest        = state_r.waitreq;
  assign analog_ctl = {state_r.comp_enable, state_r.trip_level_code,
                       state_r.warning_offset_sel};
  assign brownout_reset         = state_r.bor;
  assign cpu_hold               = state_r.hold;
  assign warning_irq            = state_r.irq;

endmodule // bom_ctrl

// *** tb/bom_ctrl_asserts.sv ***
// assertion checker for the brownout monitor control block
`timescale 1ns/1ps

module bom_ctrl_asserts #(
  parameter int FAST_CYC = bom_pkg::SAMPLE_FAST_CYC,
  parameter int SLOW_CYC = bom_pkg::SAMPLE_SLOW_CYC
) (
  // clock and reset
  input wire logic                          sys_clk,
  input wire logic                          rst,
  // register bus
  input wire logic                          avs_read,
  input wire logic                          avs_write,
  input wire logic [bom_pkg::DATA_W-1:0]    avs_readdata,
  input wire logic                          avs_waitrequest,
  // system state and analog link
  input wire logic                          deep_sleep,
  input wire bom_pkg::bom_fuse_s            fuse_in,
  input wire bom_pkg::bom_analog_s          analog_in,
  input wire bom_pkg::bom_analog_ctl_s      analog_ctl,
  input wire logic                          cpu_hold,
  input wire logic                          warning_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [1:0] up_r;
  logic       seen_r;
  int         gap_r;
  logic       wr_done;
  logic       smp;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // fuse values are live only a few edges after release
  assign wr_done = avs_write && !avs_waitrequest;
  assign smp = up_r == 2'h3 && !deep_sleep
               && fuse_in.active_mode == bom_pkg::MODE_SAMPLED;

  // cycles since release and since the last sample pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      up_r   <= 2'h0;
      seen_r <= 1'b0;
      gap_r  <= 0;
    end else begin
      if (up_r != 2'h3) up_r <= up_r + 2'h1;
      seen_r <= smp && (seen_r || analog_ctl.comp_enable);
      gap_r  <= analog_ctl.comp_enable ? 1 : gap_r + 1;
    end
  end

  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_wait_answer: assert property (s_taken |=> !avs_waitrequest)
    else $error("late answer");
  a_wait_single: assert property (!avs_waitrequest |-> s_answer)
    else $error("answer too long");
  a_wait_cause: assert property
    (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  a_data_upper: assert property
    (!avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_trip_fuse: assert property (up_r == 2'h3 |->
    analog_ctl.trip_level == fuse_in.trip_level)
    else $error("trip level differs from fuse");
  a_off_idle: assert property (up_r == 2'h3
    && fuse_in.active_mode == bom_pkg::MODE_OFF && !deep_sleep
    && !$past(deep_sleep) && !$past(deep_sleep, 2)
    |-> !analog_ctl.comp_enable)
    else $error("comparator enabled while off");
  a_pulse_width: assert property (smp && analog_ctl.comp_enable
    |=> !analog_ctl.comp_enable)
    else $error("pulse too wide");
  a_pulse_period: assert property (smp && seen_r
    && analog_ctl.comp_enable
    |-> gap_r == (fuse_in.sample_rate ? SLOW_CYC : FAST_CYC))
    else $error("sample period wrong");
  a_irq_rise: assert property ($rose(warning_irq) |->
    $past(analog_ctl.comp_enable) || $past(wr_done))
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(warning_irq) |-> $past(wr_done))
    else $error("interrupt fell without a write");
  a_hold_cause: assert property (cpu_hold |->
    !$past(analog_in.ready) && !$past(deep_sleep))
    else $error("cpu hold without cause");
  a_hold_end: assert property
    (analog_in.ready || deep_sleep |=> !cpu_hold)
    else $error("cpu hold kept after ready");
endmodule // bom_ctrl_asserts

bind bom_ctrl bom_ctrl_asserts #(.FAST_CYC(FAST_CYC),
  .SLOW_CYC(SLOW_CYC)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .deep_sleep(deep_sleep),
  .fuse_in(fuse_in), .analog_in(analog_in), .analog_ctl(analog_ctl),
  .cpu_hold(cpu_hold), .warning_irq(warning_irq)
);

// *** tb/bom_partner.sv ***
// model of the supply comparators and the boot fuse loader
`timescale 1ns/1ps

module bom_partner #(
  parameter int SETTLE = 6
) (
  // clock
  input wire logic                      sys_clk,
  // design side
  input wire bom_pkg::bom_analog_ctl_s  ctl,
  output bom_pkg::bom_fuse_s            fuse_in,
  output bom_pkg::bom_analog_s          analog_in,
  // scenario control
  input wire logic [7:0]                fuse_cfg,
  input wire logic                      below_warn,
  input wire logic                      below_trip
);
  logic [3:0] run_r = 4'h0;
  logic       tog_r = 1'b0;

  // settle counter; a disabled comparator gives garbage, not old levels
  always_ff @(posedge sys_clk) begin
    tog_r <= !tog_r;
    if (!ctl.comp_enable) run_r <= 4'h0;
    else if (run_r != 4'(SETTLE)) run_r <= run_r + 4'h1;
  end

  // fuse image is static boot data
  assign fuse_in = bom_pkg::bom_fuse_s'(fuse_cfg);
  // outputs valid only while enabled
  assign analog_in.ready = run_r == 4'(SETTLE);
  assign analog_in.warn_below = ctl.comp_enable ? below_warn : tog_r;
  assign analog_in.trip_below = ctl.comp_enable ? below_trip : tog_r;
endmodule // bom_partner

// *** tb/tb.sv ***
// self-checking testbench for the brownout monitor control block
`timescale 1ns/1ps

module tb;
  localparam int FAST = 8;
  localparam int SLOW = 32;

  logic                       sys_clk = 1'b0;
  logic                       rst;
  logic [5:0]                 avs_address = 6'h00;
  logic                       avs_read = 1'b0;
  logic                       avs_write = 1'b0;
  logic [31:0]                avs_writedata = 32'h0000_0000;
  logic [31:0]                avs_readdata;
  logic                       avs_waitrequest;
  bom_pkg::bom_fuse_s         fuse_in;
  logic                       guard;
  logic                       deep_sleep;
  bom_pkg::bom_analog_s       analog_in;
  bom_pkg::bom_analog_ctl_s   analog_ctl;
  logic                       brownout_reset;
  logic                       cpu_hold;
  logic                       warning_irq;
  logic [7:0]                 fuse_cfg;
  logic                       below_warn;
  logic                       below_trip = 1'b0;
  int                         n_errors = 0;
  int                         checks_done = 0;

  // ----------------------------------------
  // clock, design and far side
  // ----------------------------------------
  always #25 sys_clk = ~sys_clk;

  bom_ctrl #(.FAST_CYC(FAST), .SLOW_CYC(SLOW)) uut (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fuse_in(fuse_in),
    .config_change_guard(guard), .deep_sleep(deep_sleep),
    .analog_in(analog_in), .analog_ctl(analog_ctl),
    .brownout_reset(brownout_reset), .cpu_hold(cpu_hold),
    .warning_irq(warning_irq));

  bom_partner #(.SETTLE(6)) u_far (
    .sys_clk(sys_clk), .ctl(analog_ctl), .fuse_in(fuse_in),
    .analog_in(analog_in), .fuse_cfg(fuse_cfg),
    .below_warn(below_warn), .below_trip(below_trip));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  // one bus access, held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [3:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h00_0000, wd};
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 40) begin
        n_errors++;
        end_of_test();
      end
      @(posedge sys_clk);
    end
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] x;
    acc(1'b1, idx, d, x);
  endtask

  task automatic rdc(input string nm, input logic [3:0] idx,
                     input logic [7:0] exp);
    logic [7:0] x;
    acc(1'b0, idx, 8'h00, x);
    chk(nm, exp, x);
  endtask

  task automatic cy(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic do_reset(input logic [7:0] f);
    fuse_cfg <= f;
    rst <= 1'b1;
    deep_sleep <= 1'b0;
    below_warn <= 1'b0;
    guard <= 1'b0;
    cy(3);
    rst <= 1'b0;
    cy(2);
  endtask

  // counts comparator enables over a window of whole periods
  task automatic pulses(input int win, input logic [7:0] exp);
    int c;
    c = 0;
    repeat (win) begin
      @(posedge sys_clk);
      if (analog_ctl.comp_enable === 1'b1) c++;
    end
    chk("pulses", exp, 8'(c));
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    // slow sampled fuse image, reset values and access kinds
    do_reset(8'hcf);
    chk("trip", 8'h07, {5'h00, analog_ctl.trip_level});
    rdc("mode", 4'h0, 8'h19);
    rdc("level", 4'h1, 8'h07);
    rdc("offset", 4'h8, 8'h00);
    rdc("irqctl", 4'h9, 8'h00);
    rdc("flags", 4'ha, 8'h00);
    rdc("status", 4'hb, 8'h00);
    rdc("unmapped", 4'h2, 8'h00);
    wr(4'h0, 8'hff);
    rdc("mode locked", 4'h0, 8'h19);
    guard <= 1'b1;
    wr(4'h0, 8'h02);
    guard <= 1'b0;
    rdc("mode sleep", 4'h0, 8'h1a);
    wr(4'h8, 8'h02);
    rdc("offset", 4'h8, 8'h02);
    chk("offset pin", 8'h02, {6'h00, analog_ctl.warn_offset});
    pulses(3 * SLOW, 8'h03);
    do_reset(8'h40);
    cy(FAST);
    pulses(3 * FAST, 8'h03);
    // continuous detector: edge select codes 0 to 2, reserved code not driven
    do_reset(8'h22);
    rdc("mode cont", 4'h0, 8'h04);
    for (int e = 0; e < 3; e++) begin
      wr(4'h9, {5'h00, e[1:0], 1'b1});
      below_warn <= 1'b1;
      cy(3);
      rdc("flag down", 4'ha, {7'h00, e != 1});
      rdc("status low", 4'hb, 8'h01);
      wr(4'ha, 8'h01);
      below_warn <= 1'b0;
      cy(3);
      rdc("flag up", 4'ha, {7'h00, e != 0});
      rdc("status ok", 4'hb, 8'h00);
      chk("irq", {7'h00, e != 0}, {7'h00, warning_irq});
      wr(4'ha, 8'h00);
      rdc("flag kept", 4'ha, {7'h00, e != 0});
      wr(4'ha, 8'h01);
      chk("irq clear", 8'h00, {7'h00, warning_irq});
    end
    // enable off masks the request, flag still sets
    wr(4'h9, 8'h04);
    below_warn <= 1'b1;
    cy(3);
    rdc("flag masked", 4'ha, 8'h01);
    chk("irq masked", 8'h00, {7'h00, warning_irq});
    wr(4'h9, 8'h05);
    chk("irq enabled", 8'h01, {7'h00, warning_irq});
    // detector off while awake, continuous in deep sleep
    do_reset(8'h08);
    wr(4'h9, 8'h05);
    below_warn <= 1'b1;
    cy(3);
    rdc("flag off", 4'ha, 8'h00);
    deep_sleep <= 1'b1;
    cy(3);
    rdc("flag asleep", 4'ha, 8'h01);
    rdc("status asleep", 4'hb, 8'h01);
    wr(4'ha, 8'h01);
    deep_sleep <= 1'b0;
    below_warn <= 1'b0;
    cy(3);
    rdc("flag awake", 4'ha, 8'h00);
    rdc("status held", 4'hb, 8'h01);
    // hold at wake until the detector runs
    do_reset(8'h60);
    cy(2);
    chk("hold", 8'h01, {7'h00, cpu_hold});
    for (int k = 0; k < 40 && cpu_hold !== 1'b0; k++) cy(1);
    chk("hold end", 8'h00, {7'h00, cpu_hold});
    // trip comparator drives reset
    below_trip <= 1'b1;
    cy(3);
    chk("bor", 8'h01, {7'h00, brownout_reset});
    end_of_test();
  end

  // hang guard
  initial begin
    cy(20000);
    n_errors++;
    end_of_test();
  end
endmodule // tb
